// ### core/qfi_pkg.sv
package qfi_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 40;

  // Glitch filter: time per filter count and its cycle equivalent
  localparam int unsigned FILTER_STEP_NS = 100;
  localparam int unsigned FILTER_STEP_CYC =
    (FILTER_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FILTER_LIMIT_W = 6;

  // Fixed speed sampling interval
  localparam int unsigned SAMPLE_TIME_NS = 500000;
  localparam int unsigned SAMPLE_CYC_DEFAULT =
    SAMPLE_TIME_NS * CLK_MHZ / 1000;

  // Data widths
  localparam int unsigned POS_W = 32;
  localparam int unsigned SPD_W = 16;
  localparam int unsigned LINE_W = 16;
  localparam int unsigned TIME_W = 24;
  localparam int unsigned DIV_W = 40;
  localparam int unsigned SUM_W = 24;
  localparam int unsigned PTR_W = 7;
  localparam int unsigned HIST_DEPTH = 128;
  localparam int unsigned NUM_CH = 2;

  // Register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_LINE0 = 8'h04;
  localparam logic [7:0] OFF_LINE1 = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_ERROR = 8'h10;
  localparam logic [7:0] OFF_POS0 = 8'h14;
  localparam logic [7:0] OFF_POS1 = 8'h18;
  localparam logic [7:0] OFF_SPD0 = 8'h1c;
  localparam logic [7:0] OFF_SPD1 = 8'h20;

  // Configuration word layout, per channel half
  localparam int unsigned CH_STRIDE = 16;
  localparam int unsigned FILT_LSB = 0;
  localparam int unsigned MULT_LSB = 4;
  localparam int unsigned DIR_BIT = 6;
  localparam int unsigned EDGE_BIT = 7;
  localparam int unsigned TAPS_LSB = 10;
  localparam int unsigned INHIBIT_BIT = 10;

  // Multiplier codes
  localparam logic [1:0] MULT_2X_DIR = 2'h0;
  localparam logic [1:0] MULT_4X_DIR = 2'h1;
  localparam logic [1:0] MULT_1X_FWD = 2'h2;
  localparam logic [1:0] MULT_2X_FWD = 2'h3;

  // FIR tap code with the odd length
  localparam logic [2:0] TAPS_CODE_MAX = 3'h7;
  localparam logic [7:0] TAPS_MAX = 8'h7f;

  // Reset values
  localparam logic [31:0] CONFIG_RESET = 32'h0018_0018;
  localparam logic [LINE_W-1:0] LINE_RESET = 16'h03e8;

  // Line count limits and permitted bases
  localparam int LINE_MIN = 10;
  localparam int LINE_MAX = 20000;
  localparam int LINE_SHIFT_MAX = 14;
  localparam int LINE_BASES [6] = '{75, 125, 225, 375, 625, 1125};

  // True when a line count is a permitted value
  function automatic logic line_count_ok(input logic [LINE_W-1:0] v);
    logic ok;
    ok = 1'b0;
    for (int n = 0; n <= LINE_SHIFT_MAX; n++) begin
      for (int b = 0; b < 6; b++) begin
        if (int'(v) == (LINE_BASES[b] << n)) begin
          ok = 1'b1;
        end
      end
    end
    return ok && int'(v) >= LINE_MIN && int'(v) <= LINE_MAX;
  endfunction

endpackage

// ### core/glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none
module glitch_filter
  import qfi_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Level in, stability limit in cycles, filtered level out
  input wire logic i_level,
  input wire logic [FILTER_LIMIT_W-1:0] i_limit,
  output var logic o_level
);

  logic [FILTER_LIMIT_W-1:0] stable_cnt;
  logic limit_hit;

  // A change is taken once it has lasted the whole limit
  assign limit_hit = ({1'b0, stable_cnt} + 7'h01) >= {1'b0, i_limit};

  // Count cycles of disagreement; any return to the old level restarts
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
      stable_cnt <= '0;
    end else if (i_level == o_level) begin
      stable_cnt <= '0;
    end else if (limit_hit) begin
      o_level <= i_level;
      stable_cnt <= '0;
    end else begin
      stable_cnt <= stable_cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### core/speed_fir.sv
`timescale 1ns/1ps
`default_nettype none
module speed_fir
  import qfi_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // One sample: count change over elapsed cycles
  input wire logic i_start,
  input wire logic signed [SPD_W-1:0] i_delta,
  input wire logic [TIME_W-1:0] i_elapsed,
  input wire logic [TIME_W-1:0] i_interval,
  input wire logic [2:0] i_taps_code,
  // Filtered speed in counts per interval
  output var logic signed [SPD_W-1:0] o_speed
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_NORM = 5'b00010,
    ST_ACC = 5'b00100,
    ST_AVG = 5'b01000,
    ST_OUT = 5'b10000
  } fir_state_t;

  fir_state_t state;
  logic [DIV_W-1:0] rem, quo, divisor;
  logic [5:0] bit_cnt;
  logic neg;
  logic [SPD_W-1:0] hist [HIST_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W:0] fill;
  logic signed [SUM_W-1:0] sum;
  logic [2:0] taps_q;

  // Tap count and divider step
  logic [7:0] ntaps;
  logic [DIV_W-1:0] shifted, next_rem, next_quo;
  logic fits, div_last, sat, drop;
  logic [SPD_W-1:0] delta_mag, mag, raw, old_sample;
  logic [PTR_W-1:0] old_idx;
  logic signed [SUM_W-1:0] next_sum;
  logic [SUM_W-1:0] sum_mag;

  assign ntaps = (taps_q == TAPS_CODE_MAX) ? TAPS_MAX : 8'(8'h01 << taps_q);
  assign shifted = {rem[DIV_W-2:0], quo[DIV_W-1]};
  assign fits = shifted >= divisor;
  assign next_rem = fits ? shifted - divisor : shifted;
  assign next_quo = {quo[DIV_W-2:0], fits};
  assign div_last = bit_cnt == 6'(DIV_W - 1);
  assign delta_mag = i_delta[SPD_W-1] ? ~i_delta + 1'b1 : i_delta;

  // Saturate the quotient into a signed speed
  assign sat = |quo[DIV_W-1:SPD_W-1];
  assign mag = sat ? {1'b0, {(SPD_W-1){1'b1}}} : {1'b0, quo[SPD_W-2:0]};
  assign raw = neg ? ~mag + 1'b1 : mag;

  // Running sum over the newest ntaps samples
  assign old_idx = wr_ptr - ntaps[PTR_W-1:0];
  assign drop = {1'b0, fill} >= {1'b0, ntaps};
  assign old_sample = drop ? hist[old_idx] : '0;
  assign next_sum = sum + SUM_W'($signed(raw)) - SUM_W'($signed(old_sample));
  assign sum_mag = next_sum[SUM_W-1] ? ~next_sum + 1'b1 : next_sum;

  // Sample history
  always_ff @(posedge i_core_clk) begin
    if (state == ST_ACC) begin
      hist[wr_ptr] <= raw;
    end
  end

  // Normalise to one interval, accumulate, then average by tap count
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      {rem, quo, divisor} <= '0;
      bit_cnt <= '0;
      neg <= 1'b0;
      wr_ptr <= '0;
      fill <= '0;
      sum <= '0;
      taps_q <= '0;
      o_speed <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (i_taps_code != taps_q) begin
            taps_q <= i_taps_code;
            fill <= '0;
            sum <= '0;
          end else if (i_start) begin
            neg <= i_delta[SPD_W-1];
            rem <= '0;
            quo <= DIV_W'(delta_mag) * DIV_W'(i_interval);
            divisor <= DIV_W'(i_elapsed);
            bit_cnt <= '0;
            state <= ST_NORM;
          end
        end
        ST_NORM, ST_AVG: begin
          rem <= next_rem;
          quo <= next_quo;
          bit_cnt <= bit_cnt + 1'b1;
          if (div_last) begin
            state <= (state == ST_NORM) ? ST_ACC : ST_OUT;
          end
        end
        ST_ACC: begin
          wr_ptr <= wr_ptr + 1'b1;
          fill <= (fill == PTR_W'(HIST_DEPTH - 1) + 1'b1) ? fill : fill + 1'b1;
          sum <= next_sum;
          neg <= next_sum[SUM_W-1];
          rem <= '0;
          quo <= DIV_W'(sum_mag);
          divisor <= DIV_W'(ntaps);
          bit_cnt <= '0;
          state <= ST_AVG;
        end
        ST_OUT: begin
          o_speed <= raw;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### core/quadrature_feedback_input.sv
// Contract
// - Four-bit filter field per channel adds 100 ns filtering per count.
// - A phase change is accepted only after staying stable for that time.
// - Multiplier bits pick 2x dir, 4x dir, 1x forward or 2x forward.
// - With both phases, count up forward and down in reverse.
// - Forward-only multiplier codes ignore phase B; position only increases.
// - 4x mode counts every edge of both phases; an A and a B edge in the same cycle are both skipped.
// - Direction bit inverts phase A before decoding.
// - Sampling bit chooses edge-aligned or simple-difference speed.
// - Simple difference: count change over a fixed interval.
// - Edge mode stretches the interval to the next count update; a second tick with no update ends it there.
// - Tap field selects 1,2,4,8,16,32,64 or 127 FIR taps.
// - Line counts kept 10 to 20000; written value held as written.
// - Start inhibit bit 10 set while any line count is not permitted.
// - Error status word reports encoder channel error conditions.
// - Each channel publishes position and a separate speed value.
`timescale 1ns/1ps
`default_nettype none
module quadrature_feedback_input
  import qfi_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYC_DEFAULT
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output var logic o_pready,
  output var logic [31:0] o_prdata,
  output var logic o_pslverr,
  // Encoder phase pins
  input wire logic i_ch0_phase_a,
  input wire logic i_ch0_phase_b,
  input wire logic i_ch1_phase_a,
  input wire logic i_ch1_phase_b,
  // Feedback to the control loops
  output logic [POS_W-1:0] o_ch0_position_count,
  output logic [POS_W-1:0] o_ch1_position_count,
  output logic [SPD_W-1:0] o_ch0_speed_value,
  output logic [SPD_W-1:0] o_ch1_speed_value,
  output var logic o_start_inhibit
);

  // Software-visible state
  logic [31:0] quadrature_input_config;
  logic [LINE_W-1:0] channel0_line_count;
  logic [LINE_W-1:0] channel1_line_count;
  logic [NUM_CH-1:0] error_sticky;

  // Pin synchronisers
  logic [NUM_CH-1:0] a_meta, a_sync, b_meta, b_sync;

  // Per-channel results
  logic [NUM_CH-1:0] a_filt, b_filt, illegal_step;
  logic [POS_W-1:0] pos [NUM_CH];
  logic [SPD_W-1:0] speed [NUM_CH];
  logic [NUM_CH-1:0] line_count_invalid;

  // Sample interval divider
  logic [TIME_W-1:0] tick_cnt;
  logic sample_tick;

  // Bring the phase pins into the clock domain
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      a_meta <= '0;
      a_sync <= '0;
      b_meta <= '0;
      b_sync <= '0;
    end else begin
      a_meta <= {i_ch1_phase_a, i_ch0_phase_a};
      a_sync <= a_meta;
      b_meta <= {i_ch1_phase_b, i_ch0_phase_b};
      b_sync <= b_meta;
    end
  end

  // Fixed sampling interval, one-cycle tick
  assign sample_tick = tick_cnt == TIME_W'(SAMPLE_CYC - 1);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= sample_tick ? '0 : tick_cnt + 1'b1;
    end
  end

  // Decode, count and sample each channel
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [15:0] cfg;
    logic [FILTER_LIMIT_W-1:0] filt_limit;
    logic [1:0] mult;
    logic a_in, b_in, a_prev, b_prev;
    logic a_edge, b_edge, a_rise, both, fwd_a, fwd_b;
    logic uses_b, step_up, step_dn, count_evt;
    logic [POS_W-1:0] next_pos, pos_ref;
    logic [TIME_W-1:0] since_take, elapsed_q;
    logic armed, take, start_q;
    logic signed [SPD_W-1:0] delta_q;

    // Channel 1 uses the upper half of the configuration word
    assign cfg = quadrature_input_config[ch*CH_STRIDE +: 16];
    assign filt_limit = FILTER_LIMIT_W'(cfg[FILT_LSB +: 4]
                                        * FILTER_STEP_CYC);
    assign mult = cfg[MULT_LSB +: 2];

    glitch_filter u_filt_a (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_level(a_sync[ch]),
      .i_limit(filt_limit),
      .o_level(a_filt[ch])
    );

    glitch_filter u_filt_b (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_level(b_sync[ch]),
      .i_limit(filt_limit),
      .o_level(b_filt[ch])
    );

    // Phase A inverted on request, then edges against the last levels
    assign a_in = a_filt[ch] ^ cfg[DIR_BIT];
    assign b_in = b_filt[ch];
    assign a_edge = a_in ^ a_prev;
    assign b_edge = b_in ^ b_prev;
    assign a_rise = a_in & ~a_prev;
    assign both = a_edge & b_edge;
    assign fwd_a = a_in ^ b_in;
    assign fwd_b = ~(b_in ^ a_in);
    assign uses_b = (mult == MULT_2X_DIR) || (mult == MULT_4X_DIR);

    // Count steps; a double change in a direction mode is skipped
    assign step_up = (uses_b & ~both & a_edge & fwd_a)
                   | ((mult == MULT_4X_DIR) & ~both & b_edge & fwd_b)
                   | ((mult == MULT_1X_FWD) & a_rise)
                   | ((mult == MULT_2X_FWD) & a_edge);
    assign step_dn = (uses_b & ~both & a_edge & ~fwd_a)
                   | ((mult == MULT_4X_DIR) & ~both & b_edge & ~fwd_b);
    assign illegal_step[ch] = uses_b & both;
    assign count_evt = step_up | step_dn;
    assign next_pos = step_up ? pos[ch] + 1'b1
                    : step_dn ? pos[ch] - 1'b1 : pos[ch];

    // Edge mode waits past the tick for the next count update
    assign take = cfg[EDGE_BIT]
                ? ((sample_tick | armed) & count_evt) | (sample_tick & armed)
                : sample_tick;

    // Position counter and phase history
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        a_prev <= 1'b0;
        b_prev <= 1'b0;
        pos[ch] <= '0;
      end else begin
        a_prev <= a_in;
        b_prev <= b_in;
        pos[ch] <= next_pos;
      end
    end

    // Capture count change and elapsed time at each sample
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        armed <= 1'b0;
        since_take <= TIME_W'(1);
        pos_ref <= '0;
        start_q <= 1'b0;
        delta_q <= '0;
        elapsed_q <= TIME_W'(1);
      end else begin
        armed <= cfg[EDGE_BIT] & ~take & (armed | sample_tick);
        start_q <= take;
        if (take) begin
          delta_q <= SPD_W'(next_pos - pos_ref);
          elapsed_q <= since_take;
          pos_ref <= next_pos;
          since_take <= TIME_W'(1);
        end else if (~&since_take) begin
          since_take <= since_take + 1'b1;
        end
      end
    end

    speed_fir u_speed (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_start(start_q),
      .i_delta(delta_q),
      .i_elapsed(elapsed_q),
      .i_interval(TIME_W'(SAMPLE_CYC)),
      .i_taps_code(cfg[TAPS_LSB +: 3]),
      .o_speed(speed[ch])
    );
  end

  // Published feedback, straight from the counters and filters
  assign o_ch0_position_count = pos[0];
  assign o_ch1_position_count = pos[1];
  assign o_ch0_speed_value = speed[0];
  assign o_ch1_speed_value = speed[1];

  // Line count check
  assign line_count_invalid[0] = ~line_count_ok(channel0_line_count);
  assign line_count_invalid[1] = ~line_count_ok(channel1_line_count);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_start_inhibit <= 1'b0;
    end else begin
      o_start_inhibit <= |line_count_invalid;
    end
  end

  // APB decode
  logic access, write_fire, read_fire, mapped;
  logic sel_cfg, sel_line0, sel_line1, sel_status, sel_error;
  logic sel_pos0, sel_pos1, sel_spd0, sel_spd1;
  logic [31:0] wmask, read_mux, status_word;

  assign access = i_psel & i_penable;
  assign write_fire = access & o_pready & i_pwrite;
  assign read_fire = access & ~o_pready;
  assign sel_cfg = i_paddr == OFF_CONFIG;
  assign sel_line0 = i_paddr == OFF_LINE0;
  assign sel_line1 = i_paddr == OFF_LINE1;
  assign sel_status = i_paddr == OFF_STATUS;
  assign sel_error = i_paddr == OFF_ERROR;
  assign sel_pos0 = i_paddr == OFF_POS0;
  assign sel_pos1 = i_paddr == OFF_POS1;
  assign sel_spd0 = i_paddr == OFF_SPD0;
  assign sel_spd1 = i_paddr == OFF_SPD1;
  assign mapped = sel_cfg | sel_line0 | sel_line1 | sel_status | sel_error
                | sel_pos0 | sel_pos1 | sel_spd0 | sel_spd1;
  assign wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                  {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

  // Status: per-channel invalid bits and the start inhibit
  assign status_word = {21'h0, o_start_inhibit, 8'h0,
                        line_count_invalid};

  // Read selection
  assign read_mux = sel_cfg ? quadrature_input_config
                  : sel_line0 ? {16'h0, channel0_line_count}
                  : sel_line1 ? {16'h0, channel1_line_count}
                  : sel_status ? status_word
                  : sel_error ? {28'h0, line_count_invalid,
                                 error_sticky}
                  : sel_pos0 ? pos[0]
                  : sel_pos1 ? pos[1]
                  : sel_spd0 ? {{16{speed[0][SPD_W-1]}}, speed[0]}
                  : sel_spd1 ? {{16{speed[1][SPD_W-1]}}, speed[1]}
                  : 32'h0;

  // One wait state, then ready with data and error
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= read_fire;
      o_pslverr <= read_fire & ~mapped;
      if (read_fire) begin
        o_prdata <= i_pwrite ? 32'h0 : read_mux;
      end
    end
  end

  // Writable registers, byte lanes honoured
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      quadrature_input_config <= CONFIG_RESET;
      channel0_line_count <= LINE_RESET;
      channel1_line_count <= LINE_RESET;
    end else if (write_fire) begin
      if (sel_cfg) begin
        quadrature_input_config <= (quadrature_input_config & ~wmask)
                                 | (i_pwdata & wmask);
      end
      if (sel_line0) begin
        channel0_line_count <= (channel0_line_count & ~wmask[15:0])
                             | (i_pwdata[15:0] & wmask[15:0]);
      end
      if (sel_line1) begin
        channel1_line_count <= (channel1_line_count & ~wmask[15:0])
                             | (i_pwdata[15:0] & wmask[15:0]);
      end
    end
  end

  // Sticky decode errors; a new error wins over a write-one clear
  logic [NUM_CH-1:0] err_clear;

  assign err_clear = (write_fire & sel_error & i_pstrb[0])
                   ? i_pwdata[NUM_CH-1:0] : '0;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      error_sticky <= '0;
    end else begin
      error_sticky <= illegal_step | (error_sticky & ~err_clear);
    end
  end

endmodule
`default_nettype wire

// ### tb/qfi_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module qfi_assertions
  import qfi_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYC_DEFAULT
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Bus and pins
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic i_ch0_phase_a,
  input wire logic i_ch0_phase_b,
  // Watched outputs
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic [POS_W-1:0] o_ch0_position_count,
  input wire logic o_start_inhibit
);
  logic [1:0] pins_q;
  logic [6:0] quiet;

  // Cycles since a channel 0 pin last moved, saturating
  always_ff @(posedge i_core_clk) begin
    pins_q <= {i_ch0_phase_a, i_ch0_phase_b};
    quiet <= (!i_rst_n || pins_q != {i_ch0_phase_a, i_ch0_phase_b}) ?
      7'h00 : quiet + 7'(quiet != 7'h7f);
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_ready_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held too long");
  property p_ready_answer;
    i_psel && i_penable && !o_pready |=> o_pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer)
    else $error("pready late");
  property p_err_data;
    o_pslverr |-> o_pready && o_prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data)
    else $error("error reply carries data");
  property p_err_unmapped;
    o_pready && i_paddr > OFF_SPD1 |-> o_pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped address accepted");
  property p_ok_mapped;
    o_pready && i_paddr <= OFF_SPD1 && i_paddr[1:0] == 2'h0 |-> !o_pslverr;
  endproperty
  a_ok_mapped: assert property (p_ok_mapped)
    else $error("mapped address refused");
  property p_pos_step;
    (o_ch0_position_count - $past(o_ch0_position_count))
      inside {32'h0, 32'h1, 32'hffffffff};
  endproperty
  a_pos_step: assert property (p_pos_step)
    else $error("position jumped");
  property p_pos_quiet;
    quiet > 7'h50 |-> $stable(o_ch0_position_count);
  endproperty
  a_pos_quiet: assert property (p_pos_quiet)
    else $error("position moved with quiet pins");
  property p_inhibit_cause;
    $changed(o_start_inhibit) |->
      $past(o_pready && i_pwrite) || $past(o_pready && i_pwrite, 2);
  endproperty
  a_inhibit_cause: assert property (p_inhibit_cause)
    else $error("inhibit moved without a write");
  property p_rst_clear;
    @(posedge i_core_clk) disable iff (1'b0)
      !i_rst_n |=> !o_pready && o_ch0_position_count == 32'h0;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset did not clear");
endmodule
bind quadrature_feedback_input qfi_assertions #(.SAMPLE_CYC(SAMPLE_CYC))
  u_qfi_assertions (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_ch0_phase_a(i_ch0_phase_a),
  .i_ch0_phase_b(i_ch0_phase_b), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .o_ch0_position_count(o_ch0_position_count),
  .o_start_inhibit(o_start_inhibit));
`default_nettype wire

// ### tb/quadrature_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_model (
  // Clock, reset and step commands
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_rev,
  // Line receiver levels, always driven
  output var logic o_phase_a,
  output var logic o_phase_b
);
  logic [1:0] idx;

  // Gray order 00,10,11,01 is forward, one edge per step
  assign o_phase_a = idx[1] ^ idx[0];
  assign o_phase_b = idx[1];

  // Shaft angle in quarter lines
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      idx <= 2'h0;
    end else if (i_step) begin
      idx <= i_rev ? idx - 2'h1 : idx + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb/quadrature_feedback_input_test.sv
`timescale 1ns/1ps
`default_nettype none
module quadrature_feedback_input_test;
  import qfi_pkg::*;
  localparam int unsigned SCYC = 200;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, step = 1'b0, rev = 1'b0, cv = 1'b0, lerr, bad;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, pos0, pos1, r, ep = 32'h0, st;
  logic [15:0] spd0, spd1;
  logic [15:0] lv [10] = '{16'h000a, 16'h4e20, 16'h4650, 16'h0259,
    16'h2580, 16'h004b, 16'h4b00, 16'h0, 16'h0, 16'h0};
  logic pready, pslverr, inhib, pa, pb;
  logic [1:0] ti = 2'h0;
  int err_total = 0, n_tests = 0, es;

  quadrature_feedback_input #(.SAMPLE_CYC(SCYC)) u_quadrature_feedback_input (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(4'hf), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_ch0_phase_a(pa), .i_ch0_phase_b(pb),
    .i_ch1_phase_a(pa), .i_ch1_phase_b(pb), .o_ch0_position_count(pos0),
    .o_ch1_position_count(pos1), .o_ch0_speed_value(spd0),
    .o_ch1_speed_value(spd1), .o_start_inhibit(inhib));
  quadrature_encoder_model u_quadrature_encoder_model (.i_core_clk(clk),
    .i_rst_n(rst_n), .i_step(step), .i_rev(rev), .o_phase_a(pa),
    .o_phase_b(pb));

  // Clock and watchdog
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    err_total++;
    test_done();
  end

  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; pready and read data are taken at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    chk(n == 2, "pready late");
  endtask
  // Count change for one move of the decoded A and B levels
  function automatic logic [31:0] dlt(input logic [1:0] m,
      input logic ao, bo, an, bn);
    if (m == MULT_1X_FWD) return {31'h0, !ao && an};
    if (m == MULT_2X_FWD) return {31'h0, ao != an};
    if (ao != an) return (an ^ bn) ? 32'h1 : 32'hffffffff;
    if (m == MULT_4X_DIR && bo != bn) return (an == bn) ? 32'h1 : 32'hffffffff;
    return 32'h0;
  endfunction
  function automatic logic lc_ok(input int v);
    int b [6] = '{75, 125, 225, 375, 625, 1125};
    lc_ok = 1'b0;
    for (int n = 0; n < 15; n++) begin
      foreach (b[i]) begin
        if ((b[i] << n) == v && v >= LINE_MIN && v <= LINE_MAX) lc_ok = 1'b1;
      end
    end
  endfunction
  logic [1:0] cm = MULT_4X_DIR;
  task automatic mv(input logic rv);
    logic [1:0] o, n;
    o = {ti[1] ^ ti[0], ti[1]};
    ti = rv ? ti - 2'h1 : ti + 2'h1;
    n = {ti[1] ^ ti[0], ti[1]};
    ep += dlt(cm, o[1] ^ cv, o[0], n[1] ^ cv, n[0]);
    step <= 1'b1;
    rev <= rv;
    @(posedge clk);
    step <= 1'b0;
  endtask
  task automatic cfg(input logic [3:0] f, input logic [1:0] m,
                     input logic v, e, input logic [2:0] t);
    logic a;
    a = ti[1] ^ ti[0];
    ep += dlt(m, a ^ cv, ti[1], a ^ v, ti[1]);
    cv = v;
    cm = m;
    apb(1'b1, OFF_CONFIG, {2{3'h0, t, 2'h0, e, v, m, f}}, r);
  endtask

  initial begin
    void'($urandom(32'h74c91091));
    for (int k = 7; k < 10; k++) lv[k] = 16'($urandom_range(10, 20000));
    tick(5);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, OFF_CONFIG, 32'h0, r);
    chk(r === {2{3'h0, 3'h0, 2'h0, 2'h0, MULT_4X_DIR, 4'h8}}, "cfg reset");
    apb(1'b0, 8'h40, 32'h0, r);
    chk(lerr === 1'b1 && r === 32'h0, "unmapped");
    foreach (lv[k]) begin
      apb(1'b1, k[0] ? OFF_LINE1 : OFF_LINE0, {16'h0, lv[k]}, r);
      apb(1'b0, k[0] ? OFF_LINE1 : OFF_LINE0, 32'h0, r);
      chk(r[15:0] === lv[k], "line held");
      tick(3);
      chk(inhib === !lc_ok(int'(lv[k])), "inhibit");
      apb(1'b0, OFF_ERROR, 32'h0, r);
      es = int'(!lc_ok(int'(lv[k])));
      chk(r === {28'h0, 2'(es) << k[0], 2'h0}, "error word");
      apb(1'b1, k[0] ? OFF_LINE1 : OFF_LINE0, 32'h3e8, r);
    end
    for (int m = 0; m < 4; m++) begin
      for (int v = 0; v < 2; v++) begin
        cfg(4'h0, m[1:0], v[0], 1'b0, 3'h0);
        repeat (12) begin
          mv(1'($urandom_range(0, 1)));
          tick(7);
        end
        chk(pos0 === ep && pos1 === ep, "position");
      end
    end
    for (int f = 1; f < 9; f += 7) begin
      cfg(f[3:0], MULT_4X_DIR, 1'b0, 1'b0, 3'h0);
      tick(70);
      st = pos0;
      mv(1'b0);
      tick(4 * f - 3);
      mv(1'b1);
      bad = 1'b0;
      repeat (4 * f + 12) begin
        @(negedge clk);
        bad |= pos0 !== st;
      end
      @(posedge clk);
      chk(!bad, "glitch counted");
      mv(1'b0);
      tick(4 * f + 8);
      chk(pos0 === ep, "filtered edge");
    end
    for (int k = 0; k < 4; k++) begin
      cfg(4'h0, MULT_4X_DIR, k[1], k[0], 3'(k % 3));
      repeat (80) begin
        mv(1'b0);
        tick(19);
      end
      es = k[1] ? -int'(SCYC / 20) : int'(SCYC / 20);
      chk($signed(spd0) >= es - 2 && $signed(spd0) <= es + 2, "speed");
      chk(spd1 === spd0 && pos0 === ep, "feedback");
    end
    test_done();
  end
endmodule
`default_nettype wire
